// *** test_extended_memory_op_execute.sv ***
// self-checking bench for the extended memory execute unit
`timescale 1ns/100ps

module test_extended_memory_op_execute;
  import xme_pkg::*;

  localparam int DAW = 4;
  localparam int PAW = 10;

  typedef struct packed {
    logic acc_we;
    logic mem_we;
    logic zf_we;
    logic af_we;
    logic [7:0] v;
    logic z, c, ac, ov, sc;
    logic skip;
    logic tbl;
    logic [7:0] thl;
  } xme_exp_t;

  logic core_clk, srst, op_valid, op_ready, op_done, skip_taken, dummy_slot;
  logic [3:0] op_code;
  logic [DAW-1:0] op_mem_addr, dmem_addr;
  logic [2:0] op_bit_sel;
  logic [7:0] acc_in, acc_wr_data, dmem_rd_data, dmem_wr_data, ptr_wr_data;
  logic [7:0] table_pointer_low, table_pointer_high, table_high_latch;
  logic acc_wr_en, zero_flag_wr_en, arith_flag_wr_en, zero_flag, carry_flag;
  logic half_carry_flag, signed_wrap_flag, signed_compare_flag;
  logic chained_zero_flag, dmem_rd_en, dmem_wr_en, pmem_rd_en;
  logic ptr_low_wr_en, ptr_high_wr_en;
  logic [PAW-1:0] pmem_addr;
  logic [15:0] pmem_rd_data;
  logic [31:0] seed;
  logic [7:0] plo, phi;
  int errors, num_checks;

  xme_execute #(.DMEM_AW(DAW), .PMEM_AW(PAW)) i_dut (
    .core_clk, .srst, .op_valid, .op_code, .op_mem_addr, .op_bit_sel,
    .op_ready, .op_done, .skip_taken, .dummy_slot, .acc_in, .acc_wr_en,
    .acc_wr_data, .zero_flag_wr_en, .arith_flag_wr_en, .zero_flag,
    .carry_flag, .half_carry_flag, .signed_wrap_flag, .signed_compare_flag,
    .chained_zero_flag, .dmem_rd_en, .dmem_addr, .dmem_rd_data, .dmem_wr_en,
    .dmem_wr_data, .pmem_rd_en, .pmem_addr, .pmem_rd_data, .ptr_low_wr_en,
    .ptr_high_wr_en, .ptr_wr_data, .table_pointer_low, .table_pointer_high,
    .table_high_latch
  );

  xme_mem_model #(.DMEM_AW(DAW), .PMEM_AW(PAW)) i_mem (
    .core_clk, .dmem_rd_en, .dmem_addr, .dmem_rd_data, .dmem_wr_en,
    .dmem_wr_data, .pmem_rd_en, .pmem_addr, .pmem_rd_data
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] rnd8();
    seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
    return seed[7:0];
  endfunction

  // encodings as in xme_op_t
  function automatic xme_exp_t expect_of(logic [3:0] op, logic [7:0] m,
      logic [7:0] a, logic [2:0] b, logic [7:0] lo, logic [7:0] hi);
    xme_exp_t e;
    logic [PAW-1:0] pa;
    logic [15:0] w;
    e = '0;
    pa = op[0] ? PAW'({8'hFF, lo}) : PAW'({hi, lo});
    w = {pa[7:0] ^ 8'h5A, {pa[9:8], pa[5:0]} ^ 8'hC3};
    case (op)
      XME_SUBTRACT_TO_ACCUMULATOR, XME_SUBTRACT_TO_MEMORY: e.v = a - m;
      XME_NIBBLE_EXCHANGE, XME_NIBBLE_EXCHANGE_TO_ACC: e.v = {m[3:0], m[7:4]};
      XME_EXCLUSIVE_OR_TO_ACC, XME_EXCLUSIVE_OR_TO_MEMORY: e.v = a ^ m;
      XME_INCREMENT_SKIP_ON_ZERO: e.v = m + 8'h01;
      XME_TABLE_READ_PAGE, XME_TABLE_READ_LAST_PAGE: e.v = w[7:0];
      XME_INCREMENT_TABLE_READ_PAGE, XME_INCREMENT_TABLE_READ_LAST: e.v = w[7:0];
      default: e.v = m;
    endcase
    e.acc_we = op inside {4'h1, 4'h4, 4'h6, 4'hC};
    e.mem_we = op inside {4'h0, 4'h2, 4'h3, 4'h5, [4'h8:4'hB], 4'hD, 4'hE};
    e.zf_we = op inside {4'h1, 4'h2, 4'hC, 4'hD};
    e.af_we = op inside {4'h1, 4'h2};
    e.tbl = op inside {[4'h8:4'hB]};
    e.thl = w[15:8];
    e.z = (e.v == 8'h00);
    e.c = (a >= m);
    e.ac = (a[3:0] >= m[3:0]);
    e.ov = (a[7] != m[7]) && (e.v[7] != a[7]);
    e.sc = e.ov ^ e.v[7];
    if (op == 4'h0) e.skip = (e.v != 8'h00);
    else if (op inside {4'h5, 4'h6, 4'hE}) e.skip = (e.v == 8'h00);
    else if (op == 4'h7) e.skip = !m[b];
    return e;
  endfunction

  task automatic chk1(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic set_ptr(logic [7:0] lo, logic [7:0] hi);
    ptr_low_wr_en = 1'b1;
    ptr_wr_data = lo;
    @(negedge core_clk);
    ptr_low_wr_en = 1'b0;
    ptr_high_wr_en = 1'b1;
    ptr_wr_data = hi;
    @(negedge core_clk);
    ptr_high_wr_en = 1'b0;
    plo = lo;
    phi = hi;
  endtask

  // one operation from take to idle; a pointer write is tried while busy
  task automatic run_op(logic [3:0] op, logic [DAW-1:0] ad, logic [7:0] m,
      logic [7:0] a, logic [2:0] b);
    xme_exp_t e;
    int n;
    if (op inside {4'hA, 4'hB}) plo = plo + 8'h01;
    e = expect_of(op, m, a, b, plo, phi);
    i_mem.mem[ad] = m;
    op_valid = 1'b1;
    op_code = op;
    op_mem_addr = ad;
    op_bit_sel = b;
    acc_in = a;
    @(negedge core_clk);
    op_valid = 1'b0;
    ptr_low_wr_en = 1'b1;
    ptr_wr_data = rnd8();
    n = 1;
    while (op_done !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      ptr_low_wr_en = 1'b0;
      n++;
    end
    chk8(8'(n), 8'h03);
    chk1(acc_wr_en, e.acc_we);
    if (e.acc_we) chk8(acc_wr_data, e.v);
    chk1(dmem_wr_en, e.mem_we);
    if (e.mem_we) chk8(dmem_wr_data, e.v);
    if (e.mem_we) chk8(8'(dmem_addr), 8'(ad));
    chk1(zero_flag_wr_en, e.zf_we);
    chk1(arith_flag_wr_en, e.af_we);
    if (e.zf_we) chk1(zero_flag, e.z);
    if (e.af_we) begin
      chk1(carry_flag, e.c);
      chk1(half_carry_flag, e.ac);
      chk1(signed_wrap_flag, e.ov);
      chk1(signed_compare_flag, e.sc);
      chk1(chained_zero_flag, e.z);
    end
    chk1(skip_taken, e.skip);
    @(negedge core_clk);
    chk1(dummy_slot, e.skip);
    chk1(op_ready, !e.skip);
    if (e.tbl) chk8(table_high_latch, e.thl);
    chk8(table_pointer_low, plo);
    if (e.skip) begin
      @(negedge core_clk);
      chk1(op_ready, 1'b1);
    end
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end

  initial begin
    logic [7:0] cv [4];
    cv = '{8'h00, 8'hFF, 8'h80, 8'h7F};
    errors = 0;
    num_checks = 0;
    seed = 32'hA550D3EA;
    srst = 1'b1;
    op_valid = 1'b0;
    op_code = 4'h0;
    op_mem_addr = '0;
    op_bit_sel = 3'h0;
    acc_in = 8'h00;
    ptr_low_wr_en = 1'b0;
    ptr_high_wr_en = 1'b0;
    ptr_wr_data = 8'h00;
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    chk8(table_pointer_low, 8'h00);
    chk8(table_pointer_high, 8'h00);
    chk1(op_ready, 1'b1);
    // pointer low wraps across the increment variants
    set_ptr(8'hFE, 8'h02);
    for (int op = 0; op < 15; op++) begin
      for (int k = 0; k < 4; k++) begin
        run_op(4'(op), DAW'(op + k), cv[k], cv[3 - k], 3'(2 * k + 1));
      end
    end
    for (int i = 0; i < 300; i++) begin
      if (rnd8() < 8'h20) set_ptr(rnd8(), rnd8());
      run_op(4'(rnd8() % 15), DAW'(rnd8()), rnd8(), rnd8(), 3'(rnd8()));
    end
    // second reset in mid-run
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    plo = 8'h00;
    phi = 8'h00;
    chk8(table_pointer_low, 8'h00);
    chk1(op_ready, 1'b1);
    run_op(4'hB, DAW'(3), 8'h11, 8'h22, 3'h0);
    wrap_up();
  end
endmodule

// *** xme_execute.sv ***
// execute unit for extended memory skip, subtract, swap, table and xor
`timescale 1ns/100ps

// What this block does
// RULE1 - nonzero byte skip, byte rewritten unchanged
// RULE2 - taken skip inserts one dummy slot
// RULE3 - subtract to accumulator, six flags updated
// RULE4 - carry clear on negative, else set
// RULE5 - subtract to memory, same six flags
// RULE6 - swap byte nibbles in place, flags kept
// RULE7 - swapped byte to accumulator, memory kept
// RULE8 - zero byte skip, byte rewritten unchanged
// RULE9 - copy byte to accumulator, skip if zero
// RULE10 - skip when selected bit is zero
// RULE11 - table read at high:low pointer
// RULE12 - table read on last page, low pointer
// RULE13 - bump low pointer, then page read
// RULE14 - bump low pointer, then last-page read
// RULE15 - xor into accumulator, zero flag only
// RULE16 - xor into memory, zero flag only
// RULE17 - increment byte, store, skip on zero
// RULE18 - no dummy slot unless skip taken
module xme_execute
  import xme_pkg::*;
#(
  parameter int DMEM_AW = 10,
  parameter int PMEM_AW = 14
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [DMEM_AW-1:0] op_mem_addr,
  input wire logic [2:0] op_bit_sel,
  output logic op_ready,
  output logic op_done,
  output logic skip_taken,
  output logic dummy_slot,
  input wire logic [XME_DATA_W-1:0] acc_in,
  output logic acc_wr_en,
  output logic [XME_DATA_W-1:0] acc_wr_data,
  output logic zero_flag_wr_en,
  output logic arith_flag_wr_en,
  output logic zero_flag,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic signed_wrap_flag,
  output logic signed_compare_flag,
  output logic chained_zero_flag,
  output logic dmem_rd_en,
  output logic [DMEM_AW-1:0] dmem_addr,
  input wire logic [XME_DATA_W-1:0] dmem_rd_data,
  output logic dmem_wr_en,
  output logic [XME_DATA_W-1:0] dmem_wr_data,
  output logic pmem_rd_en,
  output logic [PMEM_AW-1:0] pmem_addr,
  input wire logic [XME_WORD_W-1:0] pmem_rd_data,
  input wire logic ptr_low_wr_en,
  input wire logic ptr_high_wr_en,
  input wire logic [XME_DATA_W-1:0] ptr_wr_data,
  output logic [XME_DATA_W-1:0] table_pointer_low,
  output logic [XME_DATA_W-1:0] table_pointer_high,
  output logic [XME_DATA_W-1:0] table_high_latch
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic is_zero(input logic [XME_DATA_W-1:0] v);
    return v == XME_BYTE_ZERO;
  endfunction

  function automatic logic is_table(input xme_op_t o);
    return o == XME_TABLE_READ_PAGE || o == XME_TABLE_READ_LAST_PAGE ||
           o == XME_INCREMENT_TABLE_READ_PAGE ||
           o == XME_INCREMENT_TABLE_READ_LAST;
  endfunction

  function automatic logic is_last_page(input xme_op_t o);
    return o == XME_TABLE_READ_LAST_PAGE ||
           o == XME_INCREMENT_TABLE_READ_LAST;
  endfunction

  // program word address for a table read, from the pointer pair
  function automatic logic [PMEM_AW-1:0] table_addr(input xme_op_t o,
    input logic [XME_DATA_W-1:0] lo, input logic [XME_DATA_W-1:0] hi);
    if (is_last_page(o)) begin
      return PMEM_AW'({XME_PAGE_ONES, lo});
    end
    return PMEM_AW'({hi, lo});
  endfunction

  function automatic logic [XME_DATA_W-1:0] swap_nib(
    input logic [XME_DATA_W-1:0] v);
    return {v[XME_NIB_MSB:0], v[XME_MSB:XME_NIB_W]};
  endfunction

  xme_state_t state;
  xme_op_t op;
  logic [2:0] bit_sel;
  logic take_skip;
  logic [XME_DATA_W:0] diff;
  logic [XME_NIB_W:0] diff_lo;
  logic [XME_DATA_W-1:0] xor_val;
  logic [XME_DATA_W-1:0] inc_val;
  logic sub_ov;
  logic accept;
  logic bump_ptr;
  logic [XME_DATA_W-1:0] next_ptr_low;

  assign op_ready = state == XME_IDLE;
  assign accept = op_valid && op_ready;
  assign dmem_rd_en = state == XME_READ;
  assign pmem_rd_en = state == XME_TFETCH;
  assign dummy_slot = state == XME_DUMMY;
  assign bump_ptr = accept &&
                    (xme_op_t'(op_code) == XME_INCREMENT_TABLE_READ_PAGE ||
                     xme_op_t'(op_code) == XME_INCREMENT_TABLE_READ_LAST);
  assign next_ptr_low = bump_ptr ? table_pointer_low + XME_BYTE_ONE :
                        table_pointer_low;

  // --------------------------------------------------------------------
  // datapath arithmetic on the fetched byte
  // --------------------------------------------------------------------
  assign diff = {1'b0, acc_in} - {1'b0, dmem_rd_data};
  assign diff_lo = {1'b0, acc_in[XME_NIB_MSB:0]} -
                   {1'b0, dmem_rd_data[XME_NIB_MSB:0]};
  assign sub_ov = (acc_in[XME_MSB] != dmem_rd_data[XME_MSB]) &&
                  (diff[XME_MSB] != acc_in[XME_MSB]);
  assign xor_val = acc_in ^ dmem_rd_data;
  assign inc_val = dmem_rd_data + XME_BYTE_ONE;

  always_comb begin
    case (op)
      XME_SKIP_IF_MEM_NONZERO: take_skip = !is_zero(dmem_rd_data); // see RULE1
      XME_SKIP_IF_MEM_ZERO: take_skip = is_zero(dmem_rd_data); // see RULE8
      XME_SKIP_IF_ZERO_WITH_MOVE: take_skip = is_zero(dmem_rd_data); // see RULE9
      XME_SKIP_IF_BIT_ZERO: take_skip = !dmem_rd_data[bit_sel]; // see RULE10
      XME_INCREMENT_SKIP_ON_ZERO: take_skip = is_zero(inc_val); // see RULE17
      default: take_skip = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= XME_IDLE;
    end else begin
      case (state)
        XME_IDLE: begin
          if (accept) begin
            state <= is_table(xme_op_t'(op_code)) ? XME_TFETCH : XME_READ;
          end
        end
        XME_READ: state <= XME_EXEC;
        XME_EXEC: state <= XME_WB;
        XME_TFETCH: state <= XME_TDATA;
        XME_TDATA: state <= XME_WB;
        XME_WB: state <= skip_taken ? XME_DUMMY : XME_IDLE; // see RULE2 RULE18
        XME_DUMMY: state <= XME_IDLE;
        default: state <= XME_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      op <= XME_SKIP_IF_MEM_NONZERO;
      bit_sel <= 3'h0;
      dmem_addr <= '0;
    end else if (accept) begin
      op <= xme_op_t'(op_code);
      bit_sel <= op_bit_sel;
      dmem_addr <= op_mem_addr;
    end
  end

  // --------------------------------------------------------------------
  // table pointers and program address
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      table_pointer_low <= XME_PTR_RESET;
      table_pointer_high <= XME_PTR_RESET;
    end else begin
      if (bump_ptr) begin
        table_pointer_low <= next_ptr_low; // see RULE13 RULE14
      end else if (ptr_low_wr_en && op_ready) begin
        table_pointer_low <= ptr_wr_data;
      end
      if (ptr_high_wr_en && op_ready) begin
        table_pointer_high <= ptr_wr_data;
      end
    end
  end

  // address set at the take edge so it stands during the fetch cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pmem_addr <= '0;
    end else if (accept && is_table(xme_op_t'(op_code))) begin
      pmem_addr <= table_addr(xme_op_t'(op_code), next_ptr_low,
                              table_pointer_high); // see RULE11 RULE12 RULE13 RULE14
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      table_high_latch <= XME_BYTE_ZERO;
    end else if (state == XME_TDATA) begin
      table_high_latch <= pmem_rd_data[XME_WORD_W-1:XME_DATA_W]; // see RULE11 RULE12
    end
  end

  // --------------------------------------------------------------------
  // results, strobes and flags
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dmem_wr_en <= 1'b0;
      dmem_wr_data <= XME_BYTE_ZERO;
      acc_wr_en <= 1'b0;
      acc_wr_data <= XME_BYTE_ZERO;
      skip_taken <= 1'b0;
      op_done <= 1'b0;
    end else begin
      dmem_wr_en <= 1'b0;
      acc_wr_en <= 1'b0;
      skip_taken <= 1'b0;
      op_done <= state == XME_EXEC || state == XME_TDATA;
      if (state == XME_TDATA) begin
        dmem_wr_en <= 1'b1;
        dmem_wr_data <= pmem_rd_data[XME_DATA_W-1:0]; // see RULE11 RULE12
      end else if (state == XME_EXEC) begin
        skip_taken <= take_skip; // see RULE2
        case (op)
          XME_SKIP_IF_MEM_NONZERO, XME_SKIP_IF_MEM_ZERO: begin
            dmem_wr_en <= 1'b1;
            dmem_wr_data <= dmem_rd_data; // see RULE1 RULE8
          end
          XME_SUBTRACT_TO_ACCUMULATOR: begin
            acc_wr_en <= 1'b1;
            acc_wr_data <= diff[XME_DATA_W-1:0]; // see RULE3
          end
          XME_SUBTRACT_TO_MEMORY: begin
            dmem_wr_en <= 1'b1;
            dmem_wr_data <= diff[XME_DATA_W-1:0]; // see RULE5
          end
          XME_NIBBLE_EXCHANGE: begin
            dmem_wr_en <= 1'b1;
            dmem_wr_data <= swap_nib(dmem_rd_data); // see RULE6
          end
          XME_NIBBLE_EXCHANGE_TO_ACC: begin
            acc_wr_en <= 1'b1;
            acc_wr_data <= swap_nib(dmem_rd_data); // see RULE7
          end
          XME_SKIP_IF_ZERO_WITH_MOVE: begin
            acc_wr_en <= 1'b1;
            acc_wr_data <= dmem_rd_data; // see RULE9
          end
          XME_EXCLUSIVE_OR_TO_ACC: begin
            acc_wr_en <= 1'b1;
            acc_wr_data <= xor_val; // see RULE15
          end
          XME_EXCLUSIVE_OR_TO_MEMORY: begin
            dmem_wr_en <= 1'b1;
            dmem_wr_data <= xor_val; // see RULE16
          end
          XME_INCREMENT_SKIP_ON_ZERO: begin
            dmem_wr_en <= 1'b1;
            dmem_wr_data <= inc_val; // see RULE17
          end
          default: begin
            dmem_wr_en <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      zero_flag_wr_en <= 1'b0;
      arith_flag_wr_en <= 1'b0;
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
      signed_compare_flag <= 1'b0;
      chained_zero_flag <= 1'b0;
    end else begin
      zero_flag_wr_en <= 1'b0;
      arith_flag_wr_en <= 1'b0;
      if (state == XME_EXEC && (op == XME_SUBTRACT_TO_ACCUMULATOR ||
          op == XME_SUBTRACT_TO_MEMORY)) begin
        zero_flag_wr_en <= 1'b1;
        arith_flag_wr_en <= 1'b1; // see RULE3 RULE5
        zero_flag <= is_zero(diff[XME_DATA_W-1:0]);
        carry_flag <= !diff[XME_DATA_W]; // see RULE4
        half_carry_flag <= !diff_lo[XME_NIB_W];
        signed_wrap_flag <= sub_ov;
        signed_compare_flag <= sub_ov ^ diff[XME_MSB];
        chained_zero_flag <= is_zero(diff[XME_DATA_W-1:0]);
      end else if (state == XME_EXEC && (op == XME_EXCLUSIVE_OR_TO_ACC ||
                   op == XME_EXCLUSIVE_OR_TO_MEMORY)) begin
        zero_flag_wr_en <= 1'b1; // see RULE15 RULE16
        zero_flag <= is_zero(xor_val);
      end
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_exec_skip;
    state == XME_EXEC && take_skip;
  endsequence

  sequence s_dummy_then_idle;
    skip_taken ##1 dummy_slot ##1 op_ready;
  endsequence

  a_skip_dummy_slot: assert property (@(posedge core_clk) disable iff (srst) // see RULE2
    s_exec_skip |=> s_dummy_then_idle)
    else $error("taken skip did not insert one dummy slot");

  a_no_dummy_plain: assert property (@(posedge core_clk) disable iff (srst) // see RULE18
    (state == XME_EXEC && !take_skip) |=> !skip_taken ##1 !dummy_slot)
    else $error("dummy slot without a taken skip");

  a_nonzero_skip: assert property (@(posedge core_clk) disable iff (srst) // see RULE1
    (state == XME_EXEC && op == XME_SKIP_IF_MEM_NONZERO)
    |=> skip_taken == ($past(dmem_rd_data) != XME_BYTE_ZERO) && dmem_wr_en
        && dmem_wr_data == $past(dmem_rd_data))
    else $error("nonzero skip wrong");

  a_zero_skip: assert property (@(posedge core_clk) disable iff (srst) // see RULE8
    (state == XME_EXEC && op == XME_SKIP_IF_MEM_ZERO)
    |=> skip_taken == ($past(dmem_rd_data) == XME_BYTE_ZERO) && dmem_wr_en)
    else $error("zero skip wrong");

  a_carry_sub: assert property (@(posedge core_clk) disable iff (srst) // see RULE4
    (state == XME_EXEC && op == XME_SUBTRACT_TO_MEMORY)
    |=> arith_flag_wr_en && carry_flag == ($past(acc_in) >=
        $past(dmem_rd_data)) && dmem_wr_data == $past(acc_in) -
        $past(dmem_rd_data))
    else $error("subtract carry or result wrong");

  a_swap_mem: assert property (@(posedge core_clk) disable iff (srst) // see RULE6
    (state == XME_EXEC && op == XME_NIBBLE_EXCHANGE)
    |=> dmem_wr_data == {$past(dmem_rd_data[3:0]), $past(dmem_rd_data[7:4])}
        && !zero_flag_wr_en && !acc_wr_en)
    else $error("nibble swap wrong");

  a_bit_skip: assert property (@(posedge core_clk) disable iff (srst) // see RULE10
    (state == XME_EXEC && op == XME_SKIP_IF_BIT_ZERO)
    |=> skip_taken != $past(dmem_rd_data[bit_sel]) && !dmem_wr_en)
    else $error("bit test skip wrong");

  a_table_last: assert property (@(posedge core_clk) disable iff (srst) // see RULE12
    (pmem_rd_en && is_last_page(op))
    |-> pmem_addr[7:0] == table_pointer_low ##1 1'b1 ##1
        dmem_wr_en && table_high_latch == $past(pmem_rd_data[15:8]))
    else $error("last page table read wrong");

  a_xor_acc: assert property (@(posedge core_clk) disable iff (srst) // see RULE15
    (state == XME_EXEC && op == XME_EXCLUSIVE_OR_TO_ACC)
    |=> acc_wr_en && zero_flag_wr_en && !arith_flag_wr_en)
    else $error("xor to accumulator wrong");

  a_inc_skip: assert property (@(posedge core_clk) disable iff (srst) // see RULE17
    (state == XME_EXEC && op == XME_INCREMENT_SKIP_ON_ZERO &&
     dmem_rd_data == XME_PAGE_ONES)
    |=> skip_taken && dmem_wr_data == XME_BYTE_ZERO)
    else $error("increment skip wrong");

endmodule

// *** xme_mem_model.sv ***
// data and program memory model facing the execute unit
`timescale 1ns/100ps

module xme_mem_model
#(
  parameter int DMEM_AW = 4,
  parameter int PMEM_AW = 10
) (
  input wire logic core_clk,
  input wire logic dmem_rd_en,
  input wire logic [DMEM_AW-1:0] dmem_addr,
  output logic [7:0] dmem_rd_data,
  input wire logic dmem_wr_en,
  input wire logic [7:0] dmem_wr_data,
  input wire logic pmem_rd_en,
  input wire logic [PMEM_AW-1:0] pmem_addr,
  output logic [15:0] pmem_rd_data
);
  logic [7:0] mem [2**DMEM_AW];

  initial begin
    dmem_rd_data = 8'h00;
    pmem_rd_data = 16'h0000;
  end

  // one-cycle synchronous reads; stale read data is inverted each cycle
  always @(posedge core_clk) begin
    if (dmem_wr_en) begin
      mem[dmem_addr] <= dmem_wr_data;
    end
    if (dmem_rd_en) begin
      dmem_rd_data <= mem[dmem_addr];
    end else begin
      dmem_rd_data <= ~dmem_rd_data;
    end
    if (pmem_rd_en) begin
      pmem_rd_data <= {pmem_addr[7:0] ^ 8'h5A,
                       {pmem_addr[9:8], pmem_addr[5:0]} ^ 8'hC3};
    end else begin
      pmem_rd_data <= ~pmem_rd_data;
    end
  end
endmodule

// *** xme_pkg.sv ***
// package for the extended memory operation execute unit
package xme_pkg;

  // --------------------------------------------------------------------
  // operation codes handed over by the fetch and decode stage
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    XME_SKIP_IF_MEM_NONZERO      = 4'h0,
    XME_SUBTRACT_TO_ACCUMULATOR  = 4'h1,
    XME_SUBTRACT_TO_MEMORY       = 4'h2,
    XME_NIBBLE_EXCHANGE          = 4'h3,
    XME_NIBBLE_EXCHANGE_TO_ACC   = 4'h4,
    XME_SKIP_IF_MEM_ZERO         = 4'h5,
    XME_SKIP_IF_ZERO_WITH_MOVE   = 4'h6,
    XME_SKIP_IF_BIT_ZERO         = 4'h7,
    XME_TABLE_READ_PAGE          = 4'h8,
    XME_TABLE_READ_LAST_PAGE     = 4'h9,
    XME_INCREMENT_TABLE_READ_PAGE = 4'hA,
    XME_INCREMENT_TABLE_READ_LAST = 4'hB,
    XME_EXCLUSIVE_OR_TO_ACC      = 4'hC,
    XME_EXCLUSIVE_OR_TO_MEMORY   = 4'hD,
    XME_INCREMENT_SKIP_ON_ZERO   = 4'hE
  } xme_op_t;

  // --------------------------------------------------------------------
  // one-hot execution states
  // --------------------------------------------------------------------
  typedef enum logic [6:0] {
    XME_IDLE   = 7'h01,
    XME_READ   = 7'h02,
    XME_EXEC   = 7'h04,
    XME_TFETCH = 7'h08,
    XME_TDATA  = 7'h10,
    XME_WB     = 7'h20,
    XME_DUMMY  = 7'h40
  } xme_state_t;

  // --------------------------------------------------------------------
  // widths, reset values, field positions
  // --------------------------------------------------------------------
  localparam int XME_DATA_W = 8;
  localparam int XME_NIB_W = 4;
  localparam int XME_WORD_W = 16;
  localparam logic [7:0] XME_BYTE_ZERO = 8'h00;
  localparam logic [7:0] XME_BYTE_ONE = 8'h01;
  localparam logic [7:0] XME_PTR_RESET = 8'h00;
  localparam int XME_MSB = 7;
  localparam int XME_NIB_MSB = 3;
  // program address bits above the low table pointer on the last page
  localparam logic [7:0] XME_PAGE_ONES = 8'hFF;

endpackage
